/* bench/crf_core_regs_checker.sv */
// port assertions for the core register block
module crf_core_regs_checker
(
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        rst,
	// register bus
	input wire logic [5:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	// memory port and status
	input wire logic        mem_write,
	input wire logic        mem_read,
	input wire logic [15:0] mem_address,
	input wire logic        monitor_mode,
	input wire logic        core_clock_run,
	input wire logic        break_active
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// command write accepted this cycle
	wire take_cmd = avs_write && !avs_waitrequest && avs_address[5:2] == 4'h5;
	chk_vector_fetch: assert property
		($fell(rst) |-> ##[0:4] (mem_read && mem_address == 16'hfffe)
		##[1:4] (mem_read && mem_address == 16'hffff)) else $error("reset vector fetch missing");
	chk_flag_ones: assert property
		(avs_read && avs_address[5:2] == 4'h4 |-> avs_readdata[6:5] == 2'b11)
		else $error("flag bits six and five not one");
	chk_push_down: assert property
		(mem_write && $past(mem_write) |-> mem_address == $past(mem_address) - 16'h0001)
		else $error("stack addresses not descending");
	chk_entry_frame: assert property
		($rose(mem_write) ##1 mem_write |=> mem_write [*3] ##1 !mem_write ##[0:3] mem_read)
		else $error("interrupt frame not five bytes then vector");
	chk_rsp_low: assert property
		(take_cmd && avs_writedata[4:0] == 5'h07 ##[1:2] (avs_read && avs_address[5:2] == 4'h2)
		|-> avs_readdata[7:0] == 8'hff) else $error("stack low byte not ff");
	chk_wait_halt: assert property
		(take_cmd && avs_writedata[4:0] == 5'h0f |-> ##[1:3] !core_clock_run)
		else $error("clock still runs after wait");
	chk_stop_hold: assert property
		(take_cmd && avs_writedata[4:0] == 5'h10 |-> ##[1:3] !core_clock_run [*8])
		else $error("clock not held after stop");
	chk_break_vector: assert property
		($rose(break_active) |-> ##[0:12]
		(mem_read && mem_address == (monitor_mode ? 16'hfefc : 16'hfffc)))
		else $error("break vector address wrong");
endmodule // crf_core_regs_checker

/* bench/crf_core_regs_tb_top.sv */
// self-checking bench for the core register block
`include "crf_defs.vh"
module crf_core_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	// stimulus
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic [5:0]  avs_address = 6'h00;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [7:0]  irq_request = 8'h00;
	logic        break_enable = 1'b0;
	logic        break_request = 1'b0;
	logic        monitor_mode = 1'b0;
	// observed
	wire  [31:0] avs_readdata;
	wire         avs_waitrequest, mem_write, mem_read, core_clock_run, break_active;
	wire  [15:0] mem_address;
	wire  [7:0]  mem_writedata, mem_readdata;
	int          mismatches = 0;
	int          checks_done = 0;
	int          n;
	logic [31:0] q, p;
	// alu cases: command, acc, operand, result, flags, flag care mask
	logic [4:0]  ac_cmd [8] = '{5'h01, 5'h01, 5'h03, 5'h04, 5'h05, 5'h02, 5'h06, 5'h13};
	logic [7:0]  ac_acc [8] = '{8'h7f, 8'hff, 8'h00, 8'hf0, 8'h80, 8'h01, 8'h01, 8'h05};
	logic [7:0]  ac_opd [8] = '{8'h01, 8'h01, 8'h01, 8'h0f, 8'h00, 8'h01, 8'h00, 8'h20};
	logic [7:0]  ac_res [8] = '{8'h80, 8'h00, 8'hff, 8'h00, 8'h00, 8'h03, 8'h00, 8'h05};
	logic [7:0]  ac_flg [8] = '{8'hfc, 8'h7b, 8'h6d, 8'h6a, 8'heb, 8'h68, 8'heb, 8'h01};
	logic [7:0]  ac_msk [8] = '{8'hff, 8'hff, 8'hef, 8'hee, 8'hef, 8'hff, 8'hef, 8'h01};

	crf_core_regs uut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.mem_write(mem_write), .mem_read(mem_read), .mem_address(mem_address),
		.mem_writedata(mem_writedata), .mem_readdata(mem_readdata),
		.irq_request(irq_request), .break_enable(break_enable),
		.break_request(break_request), .monitor_mode(monitor_mode),
		.core_clock_run(core_clock_run), .break_active(break_active));
	crf_mem_model mem (.sys_clk(sys_clk), .mem_write(mem_write), .mem_read(mem_read),
		.mem_address(mem_address), .mem_writedata(mem_writedata),
		.mem_readdata(mem_readdata));

	// 10 MHz clock
	initial
	begin
		forever #50 sys_clk = ~sys_clk;
	end

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		begin
			checks_done++;
			if (got !== exp)
			begin
				mismatches++;
				$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask

	// a hang counts as a mismatch and closes the run
	task automatic hang();
		begin
			mismatches++;
			report_and_stop();
		end
	endtask

	// one bus transfer, held until waitrequest is seen low before an edge
	task automatic xfer(input logic w, input logic [3:0] i, input logic [31:0] d);
		logic held;
		begin
			n = 0;
			@(posedge sys_clk);
			avs_address <= {i, 2'b00};
			avs_writedata <= d;
			avs_write <= w;
			avs_read <= !w;
			do
			begin
				@(posedge sys_clk);
				held = avs_waitrequest;
				q = avs_readdata;
				n++;
			end
			while (held !== 1'b0 && n < 9000);
			avs_write <= 1'b0;
			avs_read <= 1'b0;
			if (n >= 9000)
				hang();
		end
	endtask

	task automatic wr(input logic [3:0] i, input logic [31:0] d);
		xfer(1'b1, i, d);
	endtask

	task automatic rdchk(input logic [3:0] i, input logic [31:0] e, input logic [31:0] m);
		begin
			xfer(1'b0, i, 32'h0);
			cmp(q & m, e & m);
		end
	endtask

	task automatic cmd(input logic [4:0] c);
		wr(`CRF_IDX_CMD, {27'h0, c});
	endtask

	// a write stalls while a sequence runs, so it marks the sequencer idle
	task automatic sync();
		wr(`CRF_IDX_OPERAND, 32'h0);
	endtask

	task automatic run(input logic [4:0] c);
		begin
			cmd(c);
			sync();
		end
	endtask

	task automatic wait_run(input logic lvl);
		begin
			n = 0;
			do
			begin
				@(negedge sys_clk);
				n++;
			end
			while (core_clock_run !== lvl && n < 6000);
			if (n >= 6000)
				hang();
		end
	endtask

	task automatic t_reset();
		begin
			sync();
			rdchk(`CRF_IDX_SP, 32'h00ff, 32'hffff);
			rdchk(`CRF_IDX_FLAGS, 32'h68, 32'hff);
			rdchk(`CRF_IDX_PC, 32'h1234, 32'hffff);
		end
	endtask

	task automatic t_alu();
		for (int k = 0; k < 8; k++)
		begin
			wr(`CRF_IDX_ACC, {24'h0, ac_acc[k]});
			wr(`CRF_IDX_OPERAND, {24'h0, ac_opd[k]});
			cmd(ac_cmd[k]);
			rdchk(`CRF_IDX_ACC, {24'h0, ac_res[k]}, 32'hff);
			rdchk(`CRF_IDX_FLAGS, {24'h0, ac_flg[k]}, {24'h0, ac_msk[k]});
		end
	endtask

	task automatic t_stack();
		begin
			wr(`CRF_IDX_SP, 32'h1234);
			cmd(5'h07);
			rdchk(`CRF_IDX_SP, 32'h12ff, 32'hffff);
			wr(`CRF_IDX_OPERAND, 32'ha5);
			run(5'h08);
			rdchk(`CRF_IDX_SP, 32'h12fe, 32'hffff);
			cmp({24'h0, mem.store[16'h12ff]}, 32'ha5);
			run(5'h09);
			rdchk(`CRF_IDX_SP, 32'h12ff, 32'hffff);
			xfer(1'b0, `CRF_IDX_PC, 32'h0);
			p = q;
			run(5'h0a);
			rdchk(`CRF_IDX_PC, p + 32'h1, 32'hffff);
			wr(`CRF_IDX_IDX, 32'h4500);
			wr(`CRF_IDX_OPERAND, 32'h21);
			run(5'h0b);
			rdchk(`CRF_IDX_PC, 32'h4521, 32'hffff);
		end
	endtask

	task automatic t_irq();
		begin
			wr(`CRF_IDX_SP, 32'h00ff);
			irq_request <= 8'h24;
			repeat (10) @(posedge sys_clk);
			rdchk(`CRF_IDX_SP, 32'h00ff, 32'hffff);
			run(5'h0c);
			rdchk(`CRF_IDX_SP, 32'h00fa, 32'hffff);
			rdchk(`CRF_IDX_FLAGS, 32'h08, 32'h08);
			irq_request <= 8'h00;
			repeat (4) @(posedge sys_clk);
			run(5'h0e);
			rdchk(`CRF_IDX_SP, 32'h00ff, 32'hffff);
			rdchk(`CRF_IDX_FLAGS, 32'h00, 32'h08);
		end
	endtask

	// wait then stop, each woken by an interrupt, then each ended by reset
	task automatic t_low_power();
		begin
			for (int k = 0; k < 2; k++)
			begin
				cmd(k ? 5'h10 : 5'h0f);
				repeat (3) @(negedge sys_clk);
				cmp({31'h0, core_clock_run}, 32'h0);
				rdchk(`CRF_IDX_FLAGS, 32'h00, 32'h08);
				irq_request <= 8'h01;
				wait_run(1'b1);
				cmp({31'h0, k == 0 || n >= 4095}, 32'h1);
				sync();
				irq_request <= 8'h00;
				repeat (4) @(posedge sys_clk);
				run(5'h0e);
				rdchk(`CRF_IDX_FLAGS, 32'h00, 32'h08);
			end
			for (int k = 0; k < 2; k++)
			begin
				cmd(k ? 5'h10 : 5'h0f);
				repeat (3) @(posedge sys_clk);
				rst <= 1'b1;
				repeat (2) @(posedge sys_clk);
				rst <= 1'b0;
				sync();
				rdchk(`CRF_IDX_FLAGS, 32'h08, 32'h08);
			end
		end
	endtask

	task automatic t_break();
		begin
			break_enable <= 1'b1;
			for (int k = 0; k < 2; k++)
			begin
				monitor_mode <= k[0];
				break_request <= 1'b1;
				repeat (4) @(posedge sys_clk);
				sync();
				rdchk(`CRF_IDX_PC, k ? 32'h9abc : 32'h5678, 32'hffff);
				@(negedge sys_clk);
				cmp({31'h0, break_active}, 32'h1);
				@(posedge sys_clk);
				break_request <= 1'b0;
				repeat (4) @(posedge sys_clk);
				run(5'h0e);
				@(negedge sys_clk);
				cmp({31'h0, break_active}, 32'h0);
			end
		end
	endtask

	task automatic report_and_stop();
		begin
			if (mismatches == 0 && checks_done > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask

	// main sequence
	initial
	begin
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		t_reset();
		t_alu();
		t_stack();
		t_irq();
		t_low_power();
		t_break();
		report_and_stop();
	end
endmodule // crf_core_regs_tb_top

bind crf_core_regs crf_core_regs_checker chk (.sys_clk(sys_clk), .rst(rst),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .mem_write(mem_write), .mem_read(mem_read),
	.mem_address(mem_address), .monitor_mode(monitor_mode),
	.core_clock_run(core_clock_run), .break_active(break_active));

/* bench/crf_mem_model.sv */
// byte memory behind the stack and vector port
module crf_mem_model
(
	// clock
	input  wire logic        sys_clk,
	// memory port
	input  wire logic        mem_write,
	input  wire logic        mem_read,
	input  wire logic [15:0] mem_address,
	input  wire logic [7:0]  mem_writedata,
	output logic      [7:0]  mem_readdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] store [0:65535];
	// reset and break vectors preset, everything else zero
	initial
	begin
		for (int a = 0; a < 65536; a++)
			store[a] = 8'h00;
		store[16'hfffe] = 8'h12;
		store[16'hffff] = 8'h34;
		store[16'hfffc] = 8'h56;
		store[16'hfffd] = 8'h78;
		store[16'hfefc] = 8'h9a;
		store[16'hfefd] = 8'hbc;
		mem_readdata = 8'h00;
	end
	// data only valid the cycle after a read, toggled otherwise so stale data shows
	always @(posedge sys_clk)
	begin
		if (mem_write)
			store[mem_address] <= mem_writedata;
		mem_readdata <= mem_read ? store[mem_address] : ~mem_readdata;
	end
endmodule // crf_mem_model

/* inc/crf_defs.vh */
// constants for the core register and flag control block
// Notes on behaviour
// - eight-bit accumulator feeds and takes alu results
// - sixteen-bit index pointer from upper and lower bytes
// - reset loads stack pointer with 00ff
// - reset-stack instruction sets low byte ff only
// - stack pointer decrements on push, increments on pull
// - program counter increments per fetch, loads on jumps
// - reset loads program counter from vector fffe/ffff
// - flag register bits six and five read one
// - overflow flag follows two's complement overflow
// - half-carry on carry from bit three, add only
// - interrupt mask set blocks maskable interrupts
// - interrupt entry stacks registers, sets mask, fetches vector
// - interrupt entry never stacks the index upper byte
// - highest priority pending interrupt is served first
// - return from interrupt restores flags including mask
// - mask set after reset, cleared by clear instruction
// - negative flag copies result bit seven
// - zero flag set when result equals zero
// - carry flag from add carry, borrow, shifts
// - wait clears mask, stops clock, reset sets mask
// - stop clears mask, restarts after stabilization delay
// - break forces software interrupt, with monitor vector only in monitor mode
`ifndef CRF_DEFS_VH
`define CRF_DEFS_VH
// register indices, byte address is four times the index
`define CRF_IDX_ACC        4'h0
`define CRF_IDX_IDX        4'h1
`define CRF_IDX_SP         4'h2
`define CRF_IDX_PC         4'h3
`define CRF_IDX_FLAGS      4'h4
`define CRF_IDX_CMD        4'h5
`define CRF_IDX_OPERAND    4'h6
`define CRF_IDX_STATUS     4'h7
`define CRF_IDX_IRQ        4'h8
`define CRF_IDX_VECTOR     4'h9
// flag positions
`define CRF_F_C            0
`define CRF_F_Z            1
`define CRF_F_N            2
`define CRF_F_I            3
`define CRF_F_H            4
`define CRF_F_V            7
`define CRF_FLAGS_ONES     8'h60
`define CRF_FLAGS_RESET    8'h68
`define CRF_SP_RESET       16'h00ff
`define CRF_SP_LOW_RESET   8'hff
// vectors
`define CRF_VEC_RESET      16'hfffe
`define CRF_VEC_BREAK      16'hfffc
`define CRF_VEC_BREAK_MON  16'hfefc
// command codes written to the command register
`define CRF_CMD_ADD        5'h01
`define CRF_CMD_ADC        5'h02
`define CRF_CMD_SUB        5'h03
`define CRF_CMD_AND        5'h04
`define CRF_CMD_LSL        5'h05
`define CRF_CMD_LSR        5'h06
`define CRF_CMD_RSP        5'h07
`define CRF_CMD_PUSH       5'h08
`define CRF_CMD_PULL       5'h09
`define CRF_CMD_FETCH      5'h0a
`define CRF_CMD_JUMP       5'h0b
`define CRF_CMD_CLI        5'h0c
`define CRF_CMD_SEI        5'h0d
`define CRF_CMD_RTI        5'h0e
`define CRF_CMD_WAIT       5'h0f
`define CRF_CMD_STOP       5'h10
`define CRF_CMD_SWI        5'h11
`define CRF_CMD_DAA        5'h12
`define CRF_CMD_BTST       5'h13
// oscillator stabilization last count; settling takes one cycle more
`define CRF_STOP_DELAY     12'd4095
`endif

/* src/crf_core_regs.v */
// programmer-visible registers, flag logic and interrupt sequencing
`include "crf_defs.vh"
module crf_core_regs
(
	// clock and reset
	input  wire        sys_clk,
	input  wire        rst,
	// avalon-mm slave
	input  wire [5:0]  avs_address,
	input  wire        avs_read,
	input  wire        avs_write,
	input  wire [31:0] avs_writedata,
	output reg  [31:0] avs_readdata,
	output wire        avs_waitrequest,
	// memory port for stack and vector traffic
	output reg         mem_write,
	output reg         mem_read,
	output reg  [15:0] mem_address,
	output reg  [7:0]  mem_writedata,
	input  wire [7:0]  mem_readdata,
	// interrupt requests, bit 0 highest priority
	input  wire [7:0]  irq_request,
	input  wire        break_enable,
	input  wire        break_request,
	input  wire        monitor_mode,
	// status
	output wire        core_clock_run,
	output reg         break_active
);

	localparam ST_IDLE  = 4'd0;
	localparam ST_PUSH  = 4'd1;
	localparam ST_SETI  = 4'd2;
	localparam ST_VECH  = 4'd3;
	localparam ST_VECL  = 4'd4;
	localparam ST_PULL  = 4'd5;
	localparam ST_SLEEP = 4'd6;
	localparam ST_STAB  = 4'd7;
	localparam ST_RSTH  = 4'd8;
	localparam ST_RSTL  = 4'd9;

	reg  [7:0]  accumulator;
	reg  [15:0] index_pointer;
	reg  [15:0] stack_pointer;
	reg  [15:0] program_counter;
	reg  [7:0]  condition_flags;
	reg  [7:0]  operand;
	reg  [3:0]  state;
	reg  [2:0]  step;
	reg  [15:0] vector;
	reg         in_stop;
	reg  [11:0] stab_count;
	reg  [7:0]  irq_s1;
	reg  [7:0]  irq_s2;
	reg  [7:0]  irq_s3;
	reg  [7:0]  irq_level;
	reg  [2:0]  brk_s;
	reg         brk_level;
	reg  [2:0]  irq_vec_sel;
	reg         irq_found;
	integer     k;
	integer     j;

	wire        bus_hit = avs_write && state == ST_IDLE;
	wire        reg_sel_cmd = avs_address[5:2] == `CRF_IDX_CMD;
	wire [4:0]  cmd = avs_writedata[4:0];
	wire        do_cmd = bus_hit && reg_sel_cmd;
	wire        mask_i = condition_flags[`CRF_F_I];
	wire [7:0]  pending = irq_level & {8{~mask_i}};

	// a sequence about to start in idle wins over a write, so that write must wait too
	wire        seq_due = irq_found || (break_enable && brk_level && !break_active);

	// writes wait while a sequence runs or is due; reads answer at once
	assign avs_waitrequest = avs_write && (state != ST_IDLE || seq_due);
	assign core_clock_run = state != ST_SLEEP && state != ST_STAB;

	// pin-side inputs pass three flops; change accepted when last two agree
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			irq_s1 <= 8'h00;
			irq_s2 <= 8'h00;
			irq_s3 <= 8'h00;
			irq_level <= 8'h00;
			brk_s <= 3'h0;
			brk_level <= 1'b0;
		end
		else
		begin
			irq_s1 <= irq_request;
			irq_s2 <= irq_s1;
			irq_s3 <= irq_s2;
			for (k = 0; k < 8; k = k + 1)
				if (irq_s2[k] == irq_s3[k])
					irq_level[k] <= irq_s3[k];
			brk_s <= {brk_s[1:0], break_request};
			if (brk_s[1] == brk_s[2])
				brk_level <= brk_s[2];
		end
	end

	// lowest index wins so the most urgent request is served first
	always @*
	begin
		irq_vec_sel = 3'd0;
		irq_found = 1'b0;
		for (j = 7; j >= 0; j = j - 1)
			if (pending[j])
			begin
				irq_vec_sel = j[2:0];
				irq_found = 1'b1;
			end
	end

	// alu: result plus flags for the current command
	reg  [8:0]  sum;
	reg  [7:0]  res;
	reg  [7:0]  next_flags;
	reg         half;
	always @*
	begin
		sum = 9'h000;
		half = 1'b0;
		res = accumulator;
		next_flags = condition_flags | `CRF_FLAGS_ONES;
		case (cmd)
			`CRF_CMD_ADD, `CRF_CMD_ADC:
			begin
				sum = {1'b0, accumulator} + {1'b0, operand}
					+ {8'h00, cmd == `CRF_CMD_ADC && condition_flags[`CRF_F_C]};
				half = (accumulator[3:0] + operand[3:0]
					+ {3'h0, cmd == `CRF_CMD_ADC && condition_flags[`CRF_F_C]}) > 5'h0f;
				res = sum[7:0];
				next_flags[`CRF_F_H] = half;
				next_flags[`CRF_F_C] = sum[8];
				next_flags[`CRF_F_V] = (accumulator[7] == operand[7])
					&& (res[7] != accumulator[7]);
			end
			`CRF_CMD_SUB:
			begin
				sum = {1'b0, accumulator} - {1'b0, operand};
				res = sum[7:0];
				next_flags[`CRF_F_C] = sum[8]; // borrow
				next_flags[`CRF_F_V] = (accumulator[7] != operand[7])
					&& (res[7] != accumulator[7]);
			end
			`CRF_CMD_AND:
			begin
				res = accumulator & operand;
				next_flags[`CRF_F_V] = 1'b0;
			end
			`CRF_CMD_LSL:
			begin
				res = {accumulator[6:0], 1'b0};
				next_flags[`CRF_F_C] = accumulator[7];
				next_flags[`CRF_F_V] = accumulator[7] ^ accumulator[6];
			end
			`CRF_CMD_LSR:
			begin
				res = {1'b0, accumulator[7:1]};
				next_flags[`CRF_F_C] = accumulator[0];
				next_flags[`CRF_F_V] = accumulator[0];
			end
			`CRF_CMD_DAA:
			begin
				// correction chosen from half-carry and carry
				sum = {1'b0, accumulator};
				if (condition_flags[`CRF_F_H] || accumulator[3:0] > 4'h9)
					sum = sum + 9'h006;
				if (condition_flags[`CRF_F_C] || sum[7:0] > 8'h9f)
					sum = sum + 9'h060;
				res = sum[7:0];
				next_flags[`CRF_F_C] = condition_flags[`CRF_F_C] | sum[8];
			end
			`CRF_CMD_BTST:
			begin
				// bit test copies tested bit of operand into carry
				res = accumulator;
				next_flags[`CRF_F_C] = operand[accumulator[2:0]];
			end
			default:
				res = accumulator;
		endcase
		next_flags[`CRF_F_N] = res[7];
		next_flags[`CRF_F_Z] = res == 8'h00;
	end

	wire is_alu = cmd == `CRF_CMD_ADD || cmd == `CRF_CMD_ADC || cmd == `CRF_CMD_SUB
		|| cmd == `CRF_CMD_AND || cmd == `CRF_CMD_LSL || cmd == `CRF_CMD_LSR
		|| cmd == `CRF_CMD_DAA;

	// stacked byte for each push step: pcl, pch, x, a, flags; upper index never
	reg [7:0] push_byte;
	always @*
	begin
		case (step)
			3'd0: push_byte = program_counter[7:0];
			3'd1: push_byte = program_counter[15:8];
			3'd2: push_byte = index_pointer[7:0];
			3'd3: push_byte = accumulator;
			default: push_byte = condition_flags | `CRF_FLAGS_ONES;
		endcase
	end

	// main register and sequence process
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			accumulator <= 8'h00;
			index_pointer <= 16'h0000;
			stack_pointer <= `CRF_SP_RESET;
			program_counter <= 16'h0000;
			condition_flags <= `CRF_FLAGS_RESET;
			operand <= 8'h00;
			state <= ST_RSTH;
			step <= 3'd0;
			vector <= `CRF_VEC_RESET;
			in_stop <= 1'b0;
			stab_count <= 12'd0;
			break_active <= 1'b0;
			mem_write <= 1'b0;
			mem_read <= 1'b0;
			mem_address <= 16'h0000;
			mem_writedata <= 8'h00;
		end
		else
		begin
			mem_write <= 1'b0;
			mem_read <= 1'b0;
			case (state)
			ST_IDLE:
			begin
				if (break_enable && brk_level && !break_active)
				begin
					// break request runs a software interrupt sequence
					break_active <= 1'b1;
					vector <= monitor_mode ? `CRF_VEC_BREAK_MON : `CRF_VEC_BREAK;
					state <= ST_PUSH;
					step <= 3'd0;
				end
				else if (irq_found)
				begin
					vector <= {13'h1ffd - {10'h000, irq_vec_sel}, 3'h0} - 16'h0002;
					state <= ST_PUSH;
					step <= 3'd0;
				end
				else if (bus_hit)
				begin
					case (avs_address[5:2])
					`CRF_IDX_ACC: accumulator <= avs_writedata[7:0];
					`CRF_IDX_IDX: index_pointer <= avs_writedata[15:0];
					`CRF_IDX_SP: stack_pointer <= avs_writedata[15:0];
					`CRF_IDX_PC: program_counter <= avs_writedata[15:0];
					`CRF_IDX_FLAGS:
						// mask bit cannot be cleared here, only by clear, wait, stop or return commands
						condition_flags <= (avs_writedata[7:0] | `CRF_FLAGS_ONES)
							| {4'h0, mask_i, 3'h0};
					`CRF_IDX_OPERAND: operand <= avs_writedata[7:0];
					`CRF_IDX_CMD:
					begin
						if (is_alu)
						begin
							accumulator <= res;
							condition_flags <= next_flags;
						end
						case (cmd)
						`CRF_CMD_BTST: condition_flags <= next_flags;
						`CRF_CMD_RSP: stack_pointer[7:0] <= `CRF_SP_LOW_RESET;
						`CRF_CMD_PUSH:
						begin
							mem_write <= 1'b1;
							mem_address <= stack_pointer;
							mem_writedata <= operand;
							stack_pointer <= stack_pointer - 16'h0001;
						end
						`CRF_CMD_PULL:
						begin
							stack_pointer <= stack_pointer + 16'h0001;
							mem_read <= 1'b1;
							mem_address <= stack_pointer + 16'h0001;
						end
						`CRF_CMD_FETCH:
							program_counter <= program_counter + 16'h0001;
						`CRF_CMD_JUMP:
							program_counter <= {index_pointer[15:8], operand};
						`CRF_CMD_CLI: condition_flags[`CRF_F_I] <= 1'b0;
						`CRF_CMD_SEI: condition_flags[`CRF_F_I] <= 1'b1;
						`CRF_CMD_RTI:
						begin
							state <= ST_PULL;
							step <= 3'd0;
						end
						`CRF_CMD_WAIT, `CRF_CMD_STOP:
						begin
							condition_flags[`CRF_F_I] <= 1'b0;
							in_stop <= cmd == `CRF_CMD_STOP;
							state <= ST_SLEEP;
						end
						`CRF_CMD_SWI:
						begin
							vector <= `CRF_VEC_BREAK;
							state <= ST_PUSH;
							step <= 3'd0;
						end
						default: ;
						endcase
					end
					default: ;
					endcase
				end
			end
			ST_PUSH:
			begin
				mem_write <= 1'b1;
				mem_address <= stack_pointer;
				mem_writedata <= push_byte;
				stack_pointer <= stack_pointer - 16'h0001;
				if (step == 3'd4)
					state <= ST_SETI;
				else
					step <= step + 3'd1;
			end
			ST_SETI:
			begin
				condition_flags[`CRF_F_I] <= 1'b1; // after stacking, before vector
				mem_read <= 1'b1;
				mem_address <= vector;
				state <= ST_VECH;
			end
			ST_VECH, ST_RSTH:
			begin
				// memory data arrives one cycle after the read strobe
				mem_read <= 1'b1;
				mem_address <= vector + 16'h0001;
				state <= state == ST_RSTH ? ST_RSTL : ST_VECL;
				if (state == ST_RSTH)
				begin
					mem_read <= 1'b1;
					mem_address <= vector;
					state <= ST_VECH;
				end
			end
			ST_VECL:
			begin
				program_counter[15:8] <= mem_readdata;
				state <= ST_RSTL;
			end
			ST_RSTL:
			begin
				program_counter[7:0] <= mem_readdata;
				state <= ST_IDLE;
			end
			ST_PULL:
			begin
				// pull order: flags, a, x, pch, pcl; reads issued in steps 0-4,
				// data valid the cycle after the strobe, so taken two steps later
				case (step)
				3'd2: condition_flags <= mem_readdata | `CRF_FLAGS_ONES;
				3'd3: accumulator <= mem_readdata;
				3'd4: index_pointer[7:0] <= mem_readdata;
				3'd5: program_counter[15:8] <= mem_readdata;
				3'd6: program_counter[7:0] <= mem_readdata;
				default: ;
				endcase
				if (step == 3'd6)
				begin
					state <= ST_IDLE;
					if (!brk_level)
						break_active <= 1'b0;
				end
				else if (step < 3'd5)
				begin
					stack_pointer <= stack_pointer + 16'h0001;
					mem_read <= 1'b1;
					mem_address <= stack_pointer + 16'h0001;
				end
				step <= step + 3'd1;
			end
			ST_SLEEP:
			begin
				// any unmasked request wakes; mask stays clear
				if (irq_level != 8'h00)
				begin
					stab_count <= 12'd0;
					state <= in_stop ? ST_STAB : ST_IDLE;
				end
			end
			ST_STAB:
			begin
				// oscillator settles before the core clock runs again
				stab_count <= stab_count + 12'd1;
				if (stab_count == `CRF_STOP_DELAY)
					state <= ST_IDLE;
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

	// register read mux; unmapped indices read zero
	always @*
	begin
		case (avs_address[5:2])
			`CRF_IDX_ACC: avs_readdata = {24'h0, accumulator};
			`CRF_IDX_IDX: avs_readdata = {16'h0, index_pointer};
			`CRF_IDX_SP: avs_readdata = {16'h0, stack_pointer};
			`CRF_IDX_PC: avs_readdata = {16'h0, program_counter};
			`CRF_IDX_FLAGS: avs_readdata = {24'h0, condition_flags | `CRF_FLAGS_ONES};
			`CRF_IDX_OPERAND: avs_readdata = {24'h0, operand};
			`CRF_IDX_STATUS: avs_readdata = {24'h0, in_stop, break_active, 2'h0, state};
			`CRF_IDX_IRQ: avs_readdata = {24'h0, irq_level};
			`CRF_IDX_VECTOR: avs_readdata = {16'h0, vector};
			default: avs_readdata = 32'h0;
		endcase
	end

endmodule // crf_core_regs
